// ---- hdl/dram_hit_defs.vh ----
`ifndef DRAM_HIT_DEFS_VH
`define DRAM_HIT_DEFS_VH
// Register byte addresses
`define ADDR_MASK_0 8'h00
`define ADDR_MASK_1 8'h04
`define ADDR_BASE_0 8'h08
`define ADDR_BASE_1 8'h0c
`define ADDR_INT_STATUS 8'h10
`define ADDR_INT_MASK 8'h14
`define ADDR_HIT_STATUS 8'h18
// Mask register fields
`define MASK_REGION_HI 31
`define MASK_REGION_LO 18
`define MASK_WP_BIT 8
`define MASK_CI_BIT 6
`define MASK_AMST_BIT 5
`define MASK_SUP_FETCH_BIT 4
`define MASK_SUP_DATA_BIT 3
`define MASK_USR_FETCH_BIT 2
`define MASK_USR_DATA_BIT 1
`define MASK_VALID_BIT 0
// Writable bits; reserved 17..9 and 7 read zero
`define MASK_WRITABLE 32'hfffc017f
`define MASK_RESET 32'h00000000
`define BASE_RESET 32'h00000000
// Access type encoding
`define TYPE_CI 3'h0
`define TYPE_AMST 3'h1
`define TYPE_SUP_FETCH 3'h2
`define TYPE_SUP_DATA 3'h3
`define TYPE_USR_FETCH 3'h4
`define TYPE_USR_DATA 3'h5
// Interrupt status bits
`define INT_WP_0 0
`define INT_WP_1 1
`define INT_ACC_ERR 2
// External bus acknowledge timeout in cycles
`define EXT_ACK_TIMEOUT 8'h10
`endif

// ---- hdl/block_hit_compare.v ----
`include "dram_hit_defs.vh"
module block_hit_compare (
  input wire [31:0] addr,
  input wire [2:0] acc_type,
  input wire acc_write,
  input wire [31:0] mask,
  input wire [31:0] base,
  output wire hit,
  output wire wp_refuse
);
  wire [13:0] diff;
  wire addr_ok;
  reg type_masked;
  // Per-bit masking, any pattern
  assign diff = (addr[`MASK_REGION_HI:`MASK_REGION_LO] ^ base[`MASK_REGION_HI:`MASK_REGION_LO])
    & ~mask[`MASK_REGION_HI:`MASK_REGION_LO];
  assign addr_ok = (diff == 14'h0000);
  always @* begin
    case (acc_type)
      `TYPE_CI: type_masked = mask[`MASK_CI_BIT];
      `TYPE_AMST: type_masked = mask[`MASK_AMST_BIT];
      `TYPE_SUP_FETCH: type_masked = mask[`MASK_SUP_FETCH_BIT];
      `TYPE_SUP_DATA: type_masked = mask[`MASK_SUP_DATA_BIT];
      `TYPE_USR_FETCH: type_masked = mask[`MASK_USR_FETCH_BIT];
      `TYPE_USR_DATA: type_masked = mask[`MASK_USR_DATA_BIT];
      default: type_masked = 1'b1;
    endcase
  end
  // Qualified hit and write-lock refusal
  assign hit = addr_ok & ~type_masked & mask[`MASK_VALID_BIT]
    & ~(acc_write & mask[`MASK_WP_BIT]);
  assign wp_refuse = addr_ok & ~type_masked & mask[`MASK_VALID_BIT]
    & acc_write & mask[`MASK_WP_BIT];
endmodule

// ---- hdl/dram_block_hit_mask_decode.v ----
`include "dram_hit_defs.vh"
// Summary of operation
// - Mask bit one drops address bit compare
// - Each mask bit acts independently
// - Locked block refuses writes, raises exception
// - Refused write goes to chip-select decode unless an earlier one is pending
// - Chip-select miss issues external bus cycle
// - Unacknowledged external cycle raises access exception
// - Access-type mask bit one blocks type
// - Separate CPU-space and DMA master masks
// - One bit masks supervisor instruction fetch
// - Supervisor data, user code, user data
// - Valid clear at reset blocks decoding
module dram_block_hit_mask_decode (
  input wire mclk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire [2:0] acc_type,
  input wire acc_write,
  input wire cs_hit,
  input wire ext_ack,
  output reg hit_0,
  output reg hit_1,
  output reg addr_exception,
  output reg cs_request,
  output reg ext_cycle,
  output reg access_exception,
  output reg irq
);
  reg [31:0] mask_0_reg;
  reg [31:0] mask_1_reg;
  reg [31:0] base_0_reg;
  reg [31:0] base_1_reg;
  reg [2:0] int_status_reg;
  reg [2:0] int_mask_reg;
  reg [1:0] last_hit_reg;
  reg wait_cs_reg;
  reg wait_ack_reg;
  reg [7:0] ack_count_reg;
  reg ack_sync1_reg;
  reg ack_sync2_reg;
  reg [2:0] int_set;
  wire raw_hit_0;
  wire raw_hit_1;
  wire wp_0;
  wire wp_1;
  wire [31:0] wdata_clean;

  block_hit_compare cmp_0 (
    .addr(acc_addr),
    .acc_type(acc_type),
    .acc_write(acc_write),
    .mask(mask_0_reg),
    .base(base_0_reg),
    .hit(raw_hit_0),
    .wp_refuse(wp_0)
  );

  block_hit_compare cmp_1 (
    .addr(acc_addr),
    .acc_type(acc_type),
    .acc_write(acc_write),
    .mask(mask_1_reg),
    .base(base_1_reg),
    .hit(raw_hit_1),
    .wp_refuse(wp_1)
  );

  // Reserved bits forced clear
  assign wdata_clean = reg_wdata & `MASK_WRITABLE;

  // Acknowledge arrives from outside logic
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_sync1_reg <= 1'b0;
      ack_sync2_reg <= 1'b0;
    end else begin
      ack_sync1_reg <= ext_ack;
      ack_sync2_reg <= ack_sync1_reg;
    end
  end

  // Register writes; valid cleared at reset
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask_0_reg <= `MASK_RESET;
      mask_1_reg <= `MASK_RESET;
      base_0_reg <= `BASE_RESET;
      base_1_reg <= `BASE_RESET;
      int_mask_reg <= 3'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_MASK_0: mask_0_reg <= wdata_clean;
        `ADDR_MASK_1: mask_1_reg <= wdata_clean;
        `ADDR_BASE_0: base_0_reg <= {reg_wdata[31:18], 18'h00000};
        `ADDR_BASE_1: base_1_reg <= {reg_wdata[31:18], 18'h00000};
        `ADDR_INT_MASK: int_mask_reg <= reg_wdata[2:0];
        default: int_mask_reg <= int_mask_reg;
      endcase
    end
  end

  // Access qualification and refused-write sequence
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hit_0 <= 1'b0;
      hit_1 <= 1'b0;
      addr_exception <= 1'b0;
      cs_request <= 1'b0;
      ext_cycle <= 1'b0;
      access_exception <= 1'b0;
      last_hit_reg <= 2'h0;
      wait_cs_reg <= 1'b0;
      wait_ack_reg <= 1'b0;
      ack_count_reg <= 8'h00;
    end else begin
      hit_0 <= acc_valid & raw_hit_0;
      hit_1 <= acc_valid & raw_hit_1 & ~raw_hit_0;
      addr_exception <= acc_valid & (wp_0 | wp_1);
      cs_request <= 1'b0;
      ext_cycle <= 1'b0;
      access_exception <= 1'b0;
      if (acc_valid) begin
        last_hit_reg <= {raw_hit_1, raw_hit_0};
      end
      if (acc_valid & (wp_0 | wp_1) & ~wait_cs_reg & ~wait_ack_reg) begin
        cs_request <= 1'b1;
        wait_cs_reg <= 1'b1;
      end else if (wait_cs_reg) begin
        wait_cs_reg <= 1'b0;
        if (!cs_hit) begin
          ext_cycle <= 1'b1;
          wait_ack_reg <= 1'b1;
          ack_count_reg <= `EXT_ACK_TIMEOUT;
        end
      end else if (wait_ack_reg) begin
        if (ack_sync2_reg) begin
          wait_ack_reg <= 1'b0;
        end else if (ack_count_reg == 8'h00) begin
          wait_ack_reg <= 1'b0;
          access_exception <= 1'b1;
        end else begin
          ack_count_reg <= ack_count_reg - 8'h01;
        end
      end
    end
  end

  // Sticky interrupt events
  always @* begin
    int_set = 3'h0;
    int_set[`INT_WP_0] = acc_valid & wp_0;
    int_set[`INT_WP_1] = acc_valid & wp_1;
    int_set[`INT_ACC_ERR] = wait_ack_reg & ~ack_sync2_reg & (ack_count_reg == 8'h00);
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_status_reg <= 3'h0;
    end else if (reg_wr && reg_addr == `ADDR_INT_STATUS) begin
      int_status_reg <= (int_status_reg & ~reg_wdata[2:0]) | int_set;
    end else begin
      int_status_reg <= int_status_reg | int_set;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  // Read data one cycle after strobe
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_MASK_0: reg_rdata <= mask_0_reg;
        `ADDR_MASK_1: reg_rdata <= mask_1_reg;
        `ADDR_BASE_0: reg_rdata <= base_0_reg;
        `ADDR_BASE_1: reg_rdata <= base_1_reg;
        `ADDR_INT_STATUS: reg_rdata <= {29'h00000000, int_status_reg};
        `ADDR_INT_MASK: reg_rdata <= {29'h00000000, int_mask_reg};
        `ADDR_HIT_STATUS: reg_rdata <= {28'h0000000, wait_ack_reg, wait_cs_reg, last_hit_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// ---- bench/cs_ext_responder.sv ----
module cs_ext_responder (
  input mclk,
  input cs_request,
  input ext_cycle,
  input cs_region,
  input serve,
  output cs_hit,
  output ext_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg = 4'h0;
  logic tgl_reg = 1'b0;
  always @(posedge mclk) begin
    tgl_reg <= ~tgl_reg;
    cnt_reg <= ext_cycle ? 4'h1 : cnt_reg + {3'h0, cnt_reg != 4'h0};
  end
  // Region answer only while asked, noise otherwise
  assign cs_hit = cs_request ? cs_region : tgl_reg;
  // Acknowledge only served cycles
  assign ext_ack = serve && cnt_reg > 4'h2 && cnt_reg < 4'h6;
endmodule

// ---- bench/dram_block_hit_mask_decode_chk.sv ----
module dram_block_hit_mask_decode_chk (
  input mclk, nrst, acc_valid, acc_write, cs_hit, ext_ack,
  input hit_0, hit_1, addr_exception, cs_request, ext_cycle, access_exception,
  input [2:0] acc_type
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_HIT_SRC: assert property (hit_0 || hit_1 |-> $past(acc_valid))
    else $error("stray hit");
  AST_ONE_HIT: assert property (!(hit_0 && hit_1))
    else $error("two hits");
  AST_TYPE_BAR: assert property (acc_valid && acc_type[2:1] == 2'b11 |=> !hit_0 && !hit_1)
    else $error("bad type hit");
  AST_LOCK_SRC: assert property (addr_exception |-> $past(acc_valid && acc_write))
    else $error("stray exception");
  AST_CS_OFFER: assert property (cs_request |-> addr_exception)
    else $error("bad offer");
  AST_EXT_SRC: assert property (ext_cycle |-> $past(cs_request && !cs_hit))
    else $error("stray ext cycle");
  AST_EXT_MISS: assert property (cs_request && !cs_hit |=> ext_cycle)
    else $error("no ext cycle");
  AST_NO_ACK: assert property (ext_cycle ##1 !ext_ack [*8] ##1 !ext_ack [*8]
    |-> ##[0:4] access_exception) else $error("no access exception");
  cover property (hit_1);
  cover property (ext_cycle);
  cover property (access_exception);
endmodule
bind dram_block_hit_mask_decode dram_block_hit_mask_decode_chk i_chk (.*);

// ---- bench/dram_block_hit_mask_decode_bench.sv ----
module dram_block_hit_mask_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, acc_valid = 0, acc_write = 0;
  logic clr = 0, cs_region = 0, serve = 0, cs_hit, ext_ack, irq;
  logic hit_0, hit_1, addr_exception, cs_request, ext_cycle, access_exception;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, acc_addr = 32'h0, reg_rdata;
  logic [2:0] acc_type = 3'h0;
  logic [5:0] seen_reg;
  int fail_count = 0, checked = 0;
  dram_block_hit_mask_decode i_dram_block_hit_mask_decode (.*);
  cs_ext_responder i_cs_ext_responder (.*);
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk)
    seen_reg <= clr ? 6'h0 : seen_reg | {access_exception, ext_cycle, cs_request,
      addr_exception, hit_1, hit_0};
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic acc(input logic [31:0] a, input logic [2:0] t, input logic w,
    input logic [5:0] e);
    @(posedge mclk);
    acc_valid <= 1;
    acc_addr <= a;
    acc_type <= t;
    acc_write <= w;
    clr <= 1;
    @(posedge mclk);
    acc_valid <= 0;
    clr <= 0;
    repeat (24) @(posedge mclk);
    #1 chk(seen_reg, e);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1;
    rd(8'h00, 32'h0);
    acc(32'h0, 3'h5, 1'b0, 6'h00);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'hfffc017f);
    wr(8'h0c, 32'h80000000);
    wr(8'h04, 32'h00000001);
    wr(8'h08, 32'h40000000);
    rd(8'h08, 32'h40000000);
    wr(8'h00, 32'h80040001);
    acc(32'hc0041234, 3'h3, 1'b0, 6'h01);
    acc(32'h40100000, 3'h3, 1'b0, 6'h00);
    acc(32'h40000000, 3'h7, 1'b0, 6'h00);
    acc(32'h80000000, 3'h5, 1'b0, 6'h02);
    rd(8'h18, 32'h00000002);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 32'h1 | (32'h1 << (6 - i)));
      acc(32'h40000000, 3'(i), 1'b0, 6'h00);
      acc(32'h40000000, 3'((i + 1) % 6), 1'b1, 6'h01);
    end
    wr(8'h00, 32'h00000101);
    acc(32'h40000000, 3'h3, 1'b0, 6'h01);
    cs_region <= 1;
    acc(32'h40000000, 3'h3, 1'b1, 6'h0c);
    cs_region <= 0;
    serve <= 1;
    acc(32'h40000000, 3'h1, 1'b1, 6'h1c);
    serve <= 0;
    acc(32'h40000000, 3'h5, 1'b1, 6'h3c);
    chk(irq, 1'b0);
    rd(8'h10, 32'h5);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b1);
    wr(8'h10, 32'h7);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0);
    print_verdict;
  end
endmodule
